// [verilog/rom_cfg.svh]
// offsets, field positions, reset defaults and timing counts of the read-only array block
`ifndef ROM_CFG_SVH
`define ROM_CFG_SVH
// register byte offsets (apb, 32-byte block)
`define OFS_MODCFG   8'h00
`define OFS_BASE_HI  8'h04
`define OFS_BASE_LO  8'h08
`define OFS_SIG_HI   8'h0C
`define OFS_SIG_LO   8'h10
`define OFS_BOOT01   8'h14
`define OFS_BOOT23   8'h18
`define OFS_UNUSED   8'h1C
`define REG_SPAN     8'h20
// configuration register fields
`define CFG_STOP     15
`define CFG_BOOT     14
`define CFG_LOCK     12
`define CFG_SPACE    10
`define CFG_WAIT     8
`define BASE_LO_POS  13
// mask-programmed defaults (values arbitrary)
`define DEF_BOOT     1'b0
`define DEF_LOCK     1'b0
`define DEF_SPACE    2'h0
`define DEF_WAIT     2'h3
`define DEF_BASE     11'h000
`define DEF_SIG_HI   16'h3C5A
`define DEF_SIG_LO   16'h96E1
`define DEF_BOOT_WDS 64'h0000_0400_0200_0000
`define DEF_SEED     8'h5A
`define REG_WIN_BASE 24'hFFF820
// array geometry and timing
`define ARR_AW       13
`define CLK_PERIOD_NS 25
`define CLKS_FAST    4'h2
`define CLKS_W0      4'h3
`define CLKS_W1      4'h4
`define CLKS_W2      4'h5
`endif

// [verilog/rom_pkg.sv]
// types shared by the read-only array block
package rom_pkg;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} xfer_size_t;
	typedef enum logic {ST_IDLE, ST_BUSY} arr_state_t;
	typedef struct packed {
		logic        valid;
		logic        vector;
		logic        prog;
		xfer_size_t  size;
		logic [23:0] addr;
	} arr_req_t;
	typedef struct packed {
		logic        ack;
		logic        hit;
		logic [31:0] rdata;
	} arr_rsp_t;
endpackage

// [verilog/sync2.sv]
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	// clock
	input  logic         clk,
	// level in and out
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	// no reset: must keep following the pin while reset is held, so straps reach q
	always_ff @(posedge clk) begin
		s1_r <= d;
		q    <= s1_r;
	end
endmodule

// [verilog/rom_array.sv]
// mask-programmed array image, four big-endian byte lanes from a byte address
`timescale 1ns/1ps
module rom_array #(
	parameter int         AW   = 13,
	parameter logic [7:0] SEED = 8'h5A
) (
	// byte address inside the array
	input  logic [AW-1:0] addr,
	// bytes addr..addr+3, first byte in the top lane
	output logic [31:0]   data
);
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_lane
			logic [AW-1:0] a;
			assign a = addr + AW'(i);
			// the fixed image is a pattern of the address; wraps at the array end
			assign data[31-8*i -: 8] = a[7:0] ^ SEED ^ 8'(a >> 8);
		end
	endgenerate
endmodule

// [verilog/rom_module_ctrl.sv]
// read-only array controller: apb registers, array decode and wait-state timing
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "rom_cfg.svh"
// Functional notes
// R1: base registers take writes only while stopped and unlocked.
// R2: lock bit sets once by a write after reset; later writes ignored.
// R3: array decoded on 8-Kbyte boundary; upper address bits match base.
// R4: register block answers where the array window overlaps it.
// R5: master drives address bits 23..20 equal to bit 19.
// R6: space field low bit one limits array to program accesses.
// R7: space field resets to mask default, writable unless lock masked one.
// R8: byte or aligned word one bus cycle; long or misaligned word two.
// R9: wait field: 00 three, 01 four, 10 five, 11 two clocks.
// R10: wait field resets to mask default, writable unless lock masked one.
// R11: stop bit set refuses array access; clearing it restores access.
// R12: stop bit resets to inverse of data bit fourteen during reset.
// R13: two signature registers return a fixed mask pattern.
// R14: boot, lock, space, wait and base reset to mask defaults.
// R15: boot default zero supplies reset vectors from bootstrap words.
// R16: boot default one takes vectors from external boot memory.
// R17: 32-byte register block; unimplemented reads zero, writes ignored.
// R18: wait states delay the acknowledge per bus cycle.
module rom_module_ctrl #(
	parameter logic        BOOT_DEF   = `DEF_BOOT,
	parameter logic        LOCK_DEF   = `DEF_LOCK,
	parameter logic [1:0]  SPACE_DEF  = `DEF_SPACE,
	parameter logic [1:0]  WAIT_DEF   = `DEF_WAIT,
	parameter logic [10:0] BASE_DEF   = `DEF_BASE,
	parameter logic [15:0] SIG_HI     = `DEF_SIG_HI,
	parameter logic [15:0] SIG_LO     = `DEF_SIG_LO,
	parameter logic [63:0] BOOT_WORDS = `DEF_BOOT_WDS,
	parameter logic [23:0] REG_BASE   = `REG_WIN_BASE
) (
	// clock and reset
	input  logic              CORE_CLK,
	input  logic              RST_N,
	// apb slave
	input  logic              PSEL,
	input  logic              PENABLE,
	input  logic              PWRITE,
	input  logic [7:0]        PADDR,
	input  logic [31:0]       PWDATA,
	input  logic [3:0]        PSTRB,
	output logic [31:0]       PRDATA,
	output logic              PREADY,
	output logic              PSLVERR,
	// module bus array port
	input  rom_pkg::arr_req_t ARR_REQ,
	output rom_pkg::arr_rsp_t ARR_RSP,
	// strap and boot select
	input  logic              DATA_BIT_FOURTEEN,
	output logic              BOOT_EXTERNAL
);
	localparam int AW = `ARR_AW;

	logic                d14_s;
	logic                stop_r;
	logic                stop_nxt;
	logic                lock_r;
	logic                lock_nxt;
	logic                lock_done_r;
	logic                lock_done_nxt;
	logic                first_r;
	logic                first_nxt;
	logic [1:0]          space_r;
	logic [1:0]          space_nxt;
	logic [1:0]          wait_r;
	logic [1:0]          wait_nxt;
	logic [10:0]         base_r;
	logic [10:0]         base_nxt;
	logic [31:0]         prdata_r;
	logic [31:0]         prdata_nxt;
	logic                apb_setup;
	logic                apb_acc;
	logic                apb_err;
	logic                wr_en;
	logic [31:0]         wmask;
	logic [31:0]         wdata;
	logic [31:0]         rd_mux;
	logic [31:0]         cfg_img;
	logic                reg_win;
	logic                base_hit;
	logic                space_ok;
	logic                vec_hit;
	logic                arr_hit;
	logic                hit;
	logic                take;
	logic                two_cyc;
	logic [3:0]          bus_clks;
	logic [3:0]          total_m2;
	logic [31:0]         rom_data;
	logic [31:0]         vec_data;
	logic [127:0]        bs_wrap;
	rom_pkg::arr_state_t st_r;
	rom_pkg::arr_state_t st_nxt;
	logic [3:0]          cnt_r;
	logic [3:0]          cnt_nxt;
	logic                ack_r;
	logic                ack_nxt;
	logic [31:0]         rdata_r;
	logic [31:0]         rdata_nxt;

	sync2 #(
		.W(1)
	) u_d14 (
		.clk(CORE_CLK),
		.d  (DATA_BIT_FOURTEEN),
		.q  (d14_s)
	);

	rom_array #(
		.AW  (AW),
		.SEED(`DEF_SEED)
	) u_array (
		.addr(ARR_REQ.addr[AW-1:0]),
		.data(rom_data)
	);

	// apb decode; zero wait states, read data latched in the setup phase
	assign apb_setup = PSEL && !PENABLE;
	assign apb_acc   = PSEL && PENABLE;
	assign apb_err   = PADDR >= `REG_SPAN;
	assign wr_en     = apb_acc && PWRITE && !apb_err;
	assign PREADY    = 1'b1;
	assign PSLVERR   = apb_acc && apb_err;
	assign PRDATA    = prdata_r;
	assign BOOT_EXTERNAL = BOOT_DEF; // [R16]

	always_comb begin
		wmask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
		cfg_img = 32'h0000_0000;
		cfg_img[`CFG_STOP] = stop_r;
		cfg_img[`CFG_BOOT] = BOOT_DEF;
		cfg_img[`CFG_LOCK] = lock_r;
		cfg_img[`CFG_SPACE+1:`CFG_SPACE] = space_r;
		cfg_img[`CFG_WAIT+1:`CFG_WAIT] = wait_r;
		case (PADDR)
			`OFS_MODCFG:  rd_mux = cfg_img;
			`OFS_BASE_HI: rd_mux = {24'h00_0000, base_r[10:3]};
			`OFS_BASE_LO: rd_mux = {16'h0000, base_r[2:0], 13'h0000};
			`OFS_SIG_HI:  rd_mux = {16'h0000, SIG_HI}; // [R13]
			`OFS_SIG_LO:  rd_mux = {16'h0000, SIG_LO}; // [R13]
			`OFS_BOOT01:  rd_mux = BOOT_WORDS[63:32];
			`OFS_BOOT23:  rd_mux = BOOT_WORDS[31:0];
			default:      rd_mux = 32'h0000_0000; // [R17]
		endcase
		// lanes not strobed keep their old value
		wdata = (PWDATA & wmask) | (rd_mux & ~wmask);
	end

	// register next state
	always_comb begin
		stop_nxt      = stop_r;
		lock_nxt      = lock_r;
		lock_done_nxt = lock_done_r;
		first_nxt     = 1'b0;
		space_nxt     = space_r;
		wait_nxt      = wait_r;
		base_nxt      = base_r;
		prdata_nxt    = apb_setup ? rd_mux : prdata_r;
		if (first_r) begin
			// synchroniser still holds the level seen during reset
			stop_nxt = !d14_s; // [R12]
		end else if (wr_en) begin
			case (PADDR)
				`OFS_MODCFG: begin
					stop_nxt = wdata[`CFG_STOP]; // [R11]
					if (!lock_done_r && wdata[`CFG_LOCK]) begin
						lock_nxt      = 1'b1; // [R2]
						lock_done_nxt = 1'b1; // [R2]
					end
					if (!LOCK_DEF) begin
						space_nxt = wdata[`CFG_SPACE+1:`CFG_SPACE]; // [R7]
						wait_nxt  = wdata[`CFG_WAIT+1:`CFG_WAIT]; // [R10]
					end
				end
				`OFS_BASE_HI: begin
					if (stop_r && !lock_r) begin
						base_nxt[10:3] = wdata[7:0]; // [R1]
					end
				end
				`OFS_BASE_LO: begin
					if (stop_r && !lock_r) begin
						base_nxt[2:0] = wdata[`BASE_LO_POS+2:`BASE_LO_POS]; // [R1]
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			// stop held until the strap is loaded on the first edge
			stop_r      <= 1'b1;
			first_r     <= 1'b1;
			lock_r      <= LOCK_DEF; // [R14]
			lock_done_r <= 1'b0;
			space_r     <= SPACE_DEF; // [R14]
			wait_r      <= WAIT_DEF; // [R14]
			base_r      <= BASE_DEF; // [R14]
			prdata_r    <= 32'h0000_0000;
		end else begin
			stop_r      <= stop_nxt;
			first_r     <= first_nxt;
			lock_r      <= lock_nxt;
			lock_done_r <= lock_done_nxt;
			space_r     <= space_nxt;
			wait_r      <= wait_nxt;
			base_r      <= base_nxt;
			prdata_r    <= prdata_nxt;
		end
	end

	// array port decode
	assign reg_win  = ARR_REQ.addr[23:5] == REG_BASE[23:5]; // [R4]
	assign base_hit = ARR_REQ.addr[23:AW] == base_r; // [R3]
	assign space_ok = !space_r[0] || ARR_REQ.prog; // [R6]
	assign vec_hit  = ARR_REQ.vector && !BOOT_DEF && ARR_REQ.addr[23:3] == 21'h00_0000; // [R15]
	// vectors come from the register block, so they are served even in stop
	assign arr_hit  = !ARR_REQ.vector && !stop_r && base_hit && space_ok && !reg_win; // [R11]
	assign hit      = ARR_REQ.valid && (vec_hit || arr_hit);
	assign take     = hit && st_r == rom_pkg::ST_IDLE && !ack_r;
	assign two_cyc  = ARR_REQ.size == rom_pkg::SZ_LONG
		|| (ARR_REQ.size == rom_pkg::SZ_WORD && ARR_REQ.addr[0]); // [R8]
	assign bs_wrap  = {BOOT_WORDS, BOOT_WORDS};
	assign vec_data = bs_wrap[127 - 16 * int'(ARR_REQ.addr[2:1]) -: 32];

	always_comb begin
		case (wait_r)
			2'h0:    bus_clks = `CLKS_W0; // [R9]
			2'h1:    bus_clks = `CLKS_W1; // [R9]
			2'h2:    bus_clks = `CLKS_W2; // [R9]
			default: bus_clks = `CLKS_FAST; // [R9]
		endcase
		total_m2 = (two_cyc ? 4'(bus_clks << 1) : bus_clks) - 4'h2; // [R8]
	end

	// access timing: ack appears total-1 clocks after the request is first seen
	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		ack_nxt   = 1'b0;
		rdata_nxt = rdata_r;
		case (st_r)
			rom_pkg::ST_IDLE: begin
				if (take) begin
					rdata_nxt = ARR_REQ.vector ? vec_data : rom_data;
					if (total_m2 == 4'h0) begin
						ack_nxt = 1'b1; // [R18]
					end else begin
						st_nxt  = rom_pkg::ST_BUSY;
						cnt_nxt = total_m2 - 4'h1;
					end
				end
			end
			rom_pkg::ST_BUSY: begin
				if (cnt_r == 4'h0) begin
					ack_nxt = 1'b1; // [R18]
					st_nxt  = rom_pkg::ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 4'h1; // [R18]
				end
			end
			default: st_nxt = rom_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r    <= rom_pkg::ST_IDLE;
			cnt_r   <= 4'h0;
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			ack_r   <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign ARR_RSP.ack   = ack_r;
	assign ARR_RSP.hit   = hit;
	assign ARR_RSP.rdata = rdata_r;

	// checks
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	sequence single_take_s(logic [1:0] w);
		take && wait_r == w && !two_cyc;
	endsequence
	sequence double_take_s(logic [1:0] w);
		take && wait_r == w && two_cyc;
	endsequence

	base_guard_a: assert property ( // [R1]
		wr_en && (PADDR == `OFS_BASE_HI || PADDR == `OFS_BASE_LO) && !(stop_r && !lock_r)
		|=> $stable(base_r))
		else $error("base changed while locked or running");
	lock_hold_a: assert property ( // [R2]
		lock_r |=> lock_r)
		else $error("lock bit cleared without reset");
	array_decode_a: assert property ( // [R3]
		ARR_RSP.hit && !ARR_REQ.vector |-> ARR_REQ.addr[23:AW] == base_r)
		else $error("array answered outside its base");
	reg_overlap_a: assert property ( // [R4]
		ARR_REQ.valid && reg_win && !ARR_REQ.vector |-> !ARR_RSP.hit)
		else $error("array answered inside register block");
	space_type_a: assert property ( // [R6]
		space_r[0] && !ARR_REQ.prog && !ARR_REQ.vector |-> !ARR_RSP.hit)
		else $error("data access answered in program-only mode");
	fast_ack_a: assert property ( // [R9]
		single_take_s(2'h3) |=> ARR_RSP.ack)
		else $error("fast access not acknowledged in two clocks");
	wait0_ack_a: assert property ( // [R9]
		single_take_s(2'h0) |=> !ARR_RSP.ack ##1 ARR_RSP.ack)
		else $error("zero-wait access not acknowledged in three clocks");
	wait1_ack_a: assert property ( // [R9]
		single_take_s(2'h1) |=> !ARR_RSP.ack [*2] ##1 ARR_RSP.ack)
		else $error("one-wait access not acknowledged in four clocks");
	ack_pulse_a: assert property ( // [R18]
		ARR_RSP.ack |=> !ARR_RSP.ack)
		else $error("acknowledge longer than one clock");
	long_fast_a: assert property ( // [R8]
		double_take_s(2'h3) |=> !ARR_RSP.ack [*2] ##1 ARR_RSP.ack)
		else $error("two-cycle fast access not four clocks");
	long_wait2_a: assert property ( // [R18]
		double_take_s(2'h2) |-> ##9 ARR_RSP.ack)
		else $error("two-wait long access not ten clocks");
	mask_lock_a: assert property ( // [R10]
		LOCK_DEF || !(wr_en && PADDR == `OFS_MODCFG) |=> $stable(wait_r) && $stable(space_r))
		else $error("wait or space field changed without a config write");
	stop_refuse_a: assert property ( // [R11]
		stop_r && !ARR_REQ.vector |-> !ARR_RSP.hit)
		else $error("array answered in stop");
	strap_load_a: assert property ( // [R12]
		first_r ##1 !first_r |-> stop_r == !$past(d14_s))
		else $error("stop not loaded from strap");
	unused_zero_a: assert property ( // [R17]
		apb_setup && !PWRITE && PADDR == `OFS_UNUSED |=> PRDATA == 32'h0000_0000)
		else $error("unimplemented location not zero");
endmodule

// [sim/arr_master.sv]
// module bus master model: issues one array request and holds it until ack, or drops it as a miss when lat reaches 8'h28
`timescale 1ns/1ps
module arr_master (
	// clock and reset
	input  logic              clk,
	input  logic              rst_n,
	// command from the bench
	input  logic              go,
	input  rom_pkg::arr_req_t cmd,
	// array port
	input  rom_pkg::arr_rsp_t rsp,
	output rom_pkg::arr_req_t req,
	// outcome, held until the next command
	output logic              done,
	output logic              miss,
	output logic [7:0]        lat,
	output logic [31:0]       data
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req <= '0;
			done <= 1'b0;
			miss <= 1'b0;
			lat <= 8'h00;
			data <= 32'h0;
		end else if (go) begin
			// bench only sends addresses whose bits 23..20 copy bit 19
			req <= cmd;
			done <= 1'b0;
			miss <= 1'b0;
			lat <= 8'h01;
		end else if (req.valid) begin
			if (rsp.ack) begin
				done <= 1'b1;
				data <= rsp.rdata;
				req.valid <= 1'b0;
				// released address flips so a stale value never looks valid
				req.addr <= ~req.addr;
			end else if (lat == 8'h28) begin
				miss <= 1'b1;
				req.valid <= 1'b0;
				req.addr <= ~req.addr;
			end else begin
				lat <= lat + 8'h01;
			end
		end
	end
endmodule

// [sim/tb.sv]
// bench for the read-only array controller: registers, decode and timing
`timescale 1ns/1ps
`include "rom_cfg.svh"
module tb;
	logic              clk;
	logic              rst_n;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              strap;
	logic              boot_ext;
	logic              go;
	rom_pkg::arr_req_t cmd;
	rom_pkg::arr_req_t req;
	rom_pkg::arr_rsp_t rsp;
	logic              done;
	logic              miss;
	logic [7:0]        lat;
	logic [31:0]       data;
	logic [31:0]       q;
	logic              err;
	logic [1:0]        wcur;
	logic [63:0]       bwv = `DEF_BOOT_WDS;
	logic [3:0]        clks [4] = '{`CLKS_W0, `CLKS_W1, `CLKS_W2, `CLKS_FAST};
	int                n_mismatch;
	int                checked;

	rom_module_ctrl uut (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .ARR_REQ(req), .ARR_RSP(rsp),
		.DATA_BIT_FOURTEEN(strap), .BOOT_EXTERNAL(boot_ext));
	arr_master bm (.clk(clk), .rst_n(rst_n), .go(go), .cmd(cmd), .rsp(rsp), .req(req),
		.done(done), .miss(miss), .lat(lat), .data(data));

	initial begin
		clk = 1'b0;
		forever #(`CLK_PERIOD_NS / 2.0) clk = ~clk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] e);
		checked++;
		if (seen !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", n, e, seen);
		end
	endtask

	function automatic logic [7:0] img(input logic [12:0] a);
		return a[7:0] ^ `DEF_SEED ^ {3'h0, a[12:8]};
	endfunction

	function automatic logic [31:0] word(input logic [12:0] a);
		return {img(a), img(a + 13'h1), img(a + 13'h2), img(a + 13'h3)};
	endfunction

	function automatic logic [31:0] cv(input logic s, l, input logic [1:0] sp, w);
		logic [31:0] d;
		d = 32'h0;
		d[`CFG_STOP] = s;
		d[`CFG_LOCK] = l;
		d[`CFG_SPACE+:2] = sp;
		d[`CFG_WAIT+:2] = w;
		return d;
	endfunction

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 16) begin
			n_mismatch++;
			close_out();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, q, e);
	endtask

	task automatic cfg(input logic s, l, input logic [1:0] sp, w);
		apb(1'b1, `OFS_MODCFG, cv(s, l, sp, w));
		wcur = w;
	endtask

	// one array request through the model; latency and data worked out here
	task automatic fetch(input logic [23:0] a, input logic [1:0] sz, input logic p, v, ok);
		int i;
		logic [1:0] k;
		logic [1:0] k1;
		logic [7:0] t;
		logic [31:0] e;
		k = a[2:1];
		k1 = k + 2'h1;
		t = {4'h0, clks[wcur]};
		if (sz == 2'h2 || (sz == 2'h1 && a[0]))
			t = t * 8'h02;
		e = v ? {bwv[63 - 16 * k -: 16], bwv[63 - 16 * k1 -: 16]} : word(a[12:0]);
		@(posedge clk);
		go <= 1'b1;
		cmd <= {1'b1, v, p, sz, a};
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 60 && done !== 1'b1 && miss !== 1'b1; i++)
			@(posedge clk);
		if (i == 60) begin
			n_mismatch++;
			close_out();
		end
		chk("array hit", done, ok);
		if (ok) begin
			chk("latency", lat, t);
			chk("array data", data, e);
		end
	endtask

	task automatic rst(input logic s);
		rst_n <= 1'b0;
		strap <= s;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		wcur = `DEF_WAIT;
		repeat (2) @(posedge clk);
	endtask

	task automatic t_reset();
		rst(1'b0);
		chk("boot select", boot_ext, 1'b0);
		fetch(24'h000000, 2'h2, 1'b1, 1'b1, 1'b1);
		fetch(24'h000004, 2'h2, 1'b1, 1'b1, 1'b1);
		rd("config", `OFS_MODCFG, cv(1'b1, `DEF_LOCK, `DEF_SPACE, `DEF_WAIT));
		rd("base high", `OFS_BASE_HI, 32'h0);
		rd("base low", `OFS_BASE_LO, 32'h0);
		rd("sig high", `OFS_SIG_HI, {16'h0, `DEF_SIG_HI});
		rd("sig low", `OFS_SIG_LO, {16'h0, `DEF_SIG_LO});
		rd("boot 01", `OFS_BOOT01, bwv[63:32]);
		rd("boot 23", `OFS_BOOT23, bwv[31:0]);
		apb(1'b1, `OFS_UNUSED, 32'hFFFFFFFF);
		rd("unused", `OFS_UNUSED, 32'h0);
		rd("outside", `REG_SPAN, 32'h0);
		chk("outside err", err, 1'b1);
		$display("test reset values finished");
	endtask

	task automatic t_map();
		apb(1'b1, `OFS_BASE_HI, 32'h000000FF);
		apb(1'b1, `OFS_BASE_LO, 32'h0000E000);
		rd("base high", `OFS_BASE_HI, 32'hFF);
		cfg(1'b0, 1'b0, 2'h0, 2'h3);
		fetch(24'hFFF820, 2'h0, 1'b0, 1'b0, 1'b0);
		fetch(24'hFFE001, 2'h0, 1'b0, 1'b0, 1'b1);
		cfg(1'b1, 1'b0, 2'h0, 2'h3);
		fetch(24'hFFE000, 2'h0, 1'b0, 1'b0, 1'b0);
		apb(1'b1, `OFS_BASE_HI, 32'h00000001);
		apb(1'b1, `OFS_BASE_LO, 32'h00004000);
		cfg(1'b1, 1'b1, 2'h0, 2'h3);
		apb(1'b1, `OFS_BASE_HI, 32'h00000055);
		rd("locked base", `OFS_BASE_HI, 32'h01);
		cfg(1'b1, 1'b0, 2'h0, 2'h3);
		rd("lock kept", `OFS_MODCFG, cv(1'b1, 1'b1, 2'h0, 2'h3));
		cfg(1'b0, 1'b1, 2'h0, 2'h3);
		fetch(24'h015FFF, 2'h0, 1'b0, 1'b0, 1'b1);
		fetch(24'h016000, 2'h0, 1'b0, 1'b0, 1'b0);
		$display("test mapping finished");
	endtask

	task automatic t_wait();
		for (int w = 0; w < 4; w++) begin
			cfg(1'b0, 1'b1, 2'h0, w[1:0]);
			rd("wait field", `OFS_MODCFG, cv(1'b0, 1'b1, 2'h0, w[1:0]));
			fetch(24'h014010, 2'h0, 1'b0, 1'b0, 1'b1);
			fetch(24'h014012, 2'h1, 1'b0, 1'b0, 1'b1);
			fetch(24'h014010, 2'h2, 1'b0, 1'b0, 1'b1);
			fetch(24'h014011, 2'h1, 1'b0, 1'b0, 1'b1);
		end
		$display("test wait states finished");
	endtask

	task automatic t_space();
		cfg(1'b0, 1'b1, 2'h1, 2'h3);
		fetch(24'h014020, 2'h0, 1'b0, 1'b0, 1'b0);
		fetch(24'h014020, 2'h0, 1'b1, 1'b0, 1'b1);
		cfg(1'b0, 1'b1, 2'h2, 2'h3);
		rd("space field", `OFS_MODCFG, cv(1'b0, 1'b1, 2'h2, 2'h3));
		fetch(24'h014020, 2'h0, 1'b0, 1'b0, 1'b1);
		$display("test space type finished");
	endtask

	task automatic t_strap();
		rst(1'b1);
		rd("config", `OFS_MODCFG, cv(1'b0, `DEF_LOCK, `DEF_SPACE, `DEF_WAIT));
		rd("base high", `OFS_BASE_HI, 32'h0);
		$display("test second reset finished");
	endtask

	initial begin
		rst_n = 1'b0;
		strap = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		go = 1'b0;
		cmd = '0;
		wcur = `DEF_WAIT;
		n_mismatch = 0;
		checked = 0;
		t_reset();
		t_map();
		t_wait();
		t_space();
		t_strap();
		close_out();
	end
endmodule
